// [logic/system_memory_address_decoder.sv]
`timescale 1ns/100ps
// Operation
// RULE1 - accesses at or above 4 GB terminate locally, writes dropped, reads zero
// RULE2 - eight-bit page selector picks the 64 KB display cache page
// RULE3 - lowest 640 KB always goes to main DRAM
// RULE4 - video buffer ignores shadow bits, steered by graphics select and VGA bits
// RULE5 - video buffer steering identical for host and hub initiators; code sends host SMM accesses to DRAM when smmVgaOpen is set
// RULE6 - SMM accesses to video buffer follow control_a settings
// RULE7 - four 64 KB shadow segments each read/write, write-only, read-only or off
// RULE8 - CD hole with cd_hole_enable set always forwards to PCI
// RULE9 - CD hole with cd_hole_enable clear follows shadow attribute bits 3:2
// RULE10 - mono adapter range steered by graphics select, command and VGA bits
// RULE11 - 1 MB up to top_of_memory goes to DRAM except enabled holes
// RULE12 - optional 15-16 MB hole forwards to PCI, DRAM not relocated
// RULE13 - CONTROL_A top segment below top_of_memory; non-SMM and hub accesses go to PCI
// RULE14 - graphics stolen memory sits below top segment, else below top_of_memory
// RULE15 - top_of_memory to 4 GB forwards to PCI unless specially decoded
// RULE16 - 512 KB window at mmio_base decodes to graphics control registers
// RULE17 - VGA registers also answer at their legacy I/O ports
// RULE18 - 4 GB memory space and 64 KB plus 3 bytes of I/O space
// RULE19 - software keeps decode ranges from overlapping; no interlock exists
// RULE20 - page mapping enable opens paged window at A0000h-AFFFFh
// RULE21 - paging target bit picks VGA buffer or display cache for the window
module system_memory_address_decoder
(
	input  wire logic                      clk,      // host clock, 100 MHz
	input  wire logic                      reset,    // synchronous, active high
	input  wire sys_decode_pkg::request_s  req,      // access to decode
	input  wire sys_decode_pkg::config_s   cfg,      // decode controls
	output sys_decode_pkg::response_s      resp      // routing decision, one cycle later
);
	import sys_decode_pkg::*;

	logic [7:0]  indexReg;        // graphics index port latch
	logic [7:0]  addrMapReg;      // address mapping register
	logic [7:0]  pageSelReg;      // display_cache_page_select
	response_s   respReg;
	response_s   respNext;

	logic [35:0] addr;
	logic [16:0] ioAddr;
	logic        isRead;
	logic        gfxVga;
	logic        pageWinOn;
	logic [35:0] top_of_memory;
	logic [35:0] tsegSize;
	logic [35:0] tsegBase;
	logic [35:0] stolenSize;
	logic [35:0] stolenTop;
	logic [35:0] stolenBase;
	logic [35:0] mmioLo;
	logic [1:0]  segIdx;
	logic [3:0]  segAttr;
	logic [1:0]  attr;
	logic        inVga;
	logic        inPageWin;
	logic        inMda;
	logic        inShadow;
	logic        inCdHole;
	logic        inIsaHole;
	logic        inTseg;
	logic        inStolen;
	logic        inMmio;
	logic        ioVga;
	logic        ioMda;
	logic        ioIndex;
	logic        ioData;
	logic        ioTaken;
	logic [7:0]  ioRdata;

	assign addr   = req.addr;
	assign ioAddr = req.addr[16:0];                                // RULE18
	assign isRead = !req.write;

	// graphics device owns legacy VGA only when it has memory and is enabled
	assign gfxVga    = (cfg.graphics_memory_select != GMS_OFF) && cfg.vgaEnable;
	assign pageWinOn = gfxVga && addrMapReg[MAP_PAGE_EN];           // RULE20

	// top of memory and the holes stacked beneath it
	assign top_of_memory        = {4'h0, cfg.topOfMemory};
	assign tsegSize   = cfg.upperSmramSize ? SIZE_1M : SIZE_512K;   // RULE13
	assign tsegBase   = top_of_memory - tsegSize;
	assign stolenSize = (cfg.graphics_memory_select == GMS_512K) ? SIZE_512K : SIZE_1M;
	assign stolenTop  = cfg.smramTopEnable ? tsegBase : top_of_memory;        // RULE14
	assign stolenBase = stolenTop - stolenSize;
	assign mmioLo     = {4'h0, cfg.mmioBase, 19'h0_0000};

	// compatibility area range hits
	assign inVga     = (addr >= VGA_BASE) && (addr < VGA_END);
	assign inPageWin = (addr >= VGA_BASE) && (addr < PAGE_WIN_END);
	assign inMda     = (addr >= MDA_BASE) && (addr < MDA_END);
	assign inShadow  = (addr >= VGA_END) && (addr < ONE_MB);
	assign inCdHole  = (addr >= CD_HOLE_BASE) && (addr < CD_HOLE_END);

	// extended area range hits; overlaps are software's problem
	assign inIsaHole = cfg.fixedHoleEnable
		&& (addr >= ISA_HOLE_BASE) && (addr < ISA_HOLE_END);         // RULE12
	assign inTseg    = cfg.smramTopEnable
		&& (addr >= tsegBase) && (addr < top_of_memory);                      // RULE13
	assign inStolen  = cfg.gfxMemEnable && (cfg.graphics_memory_select != GMS_OFF)
		&& (addr >= stolenBase) && (addr < stolenTop);              // RULE14
	assign inMmio    = (addr >= mmioLo) && (addr < mmioLo + MMIO_SIZE); // RULE16

	// shadow segment attribute; CD hole uses the upper field
	assign segIdx  = addr[SEG_LSB +: 2];
	assign segAttr = cfg.shadowAttr[segIdx];
	assign attr    = inCdHole ? segAttr[ATTR_CD_LSB +: 2]
	                          : segAttr[ATTR_SEG_LSB +: 2];            // RULE9

	// legacy I/O port hits, upper alias bits 15:10 ignored, wrap bit must be clear
	assign ioIndex = ioAddr[9:0] == GFX_INDEX_PORT[9:0] && !ioAddr[16];
	assign ioData  = ioAddr[9:0] == GFX_DATA_PORT[9:0] && !ioAddr[16];
	assign ioVga   = !ioAddr[16] && ioAddr[9:0] >= VGA_IO_LO[9:0]
		&& ioAddr[9:0] <= VGA_IO_HI[9:0];
	assign ioMda   = !ioAddr[16] && ioAddr[9:0] >= MDA_IO_LO[9:0]
		&& ioAddr[9:0] <= MDA_IO_HI[9:0];
	// hub initiators never reach the graphics I/O registers
	assign ioTaken = req.valid && req.isIo && !req.fromHub && gfxVga;

	// read data of the graphics index and data ports
	always_comb
	begin
		ioRdata = 8'h00;
		if (ioIndex)
		begin
			ioRdata = indexReg;
		end
		else if (ioData && indexReg == ADDR_MAP_INDEX)
		begin
			ioRdata = addrMapReg;
		end
		else if (ioData && indexReg == PAGE_SEL_INDEX)
		begin
			ioRdata = pageSelReg;
		end
	end

	// graphics index latch
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			indexReg <= INDEX_RESET;
		end
		else if (ioTaken && req.write && ioIndex)
		begin
			indexReg <= req.wdata;
		end
	end

	// indexed registers behind the data port
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			addrMapReg <= ADDR_MAP_RESET;
			pageSelReg <= PAGE_SEL_RESET;
		end
		else if (ioTaken && req.write && ioData)
		begin
			if (indexReg == ADDR_MAP_INDEX)
			begin
				addrMapReg <= req.wdata;                                // RULE21
			end
			if (indexReg == PAGE_SEL_INDEX)
			begin
				pageSelReg <= req.wdata;                                // RULE2
			end
		end
	end

	// routing decision; one comparator chain, I/O and 4 GB and up first, then from low addresses up
	always_comb
	begin
		respNext           = '0;
		respNext.valid     = req.valid;
		respNext.target    = TGT_HUB;
		respNext.fwdAddr   = addr[31:0];
		if (req.isIo)
		begin
			// I/O space: graphics registers when enabled, everything else to hub
			if (ioAddr == HERC_IO_PORT)
			begin
				respNext.target = TGT_HUB;
			end
			else if (ioTaken && (ioVga || (ioMda && cfg.mdaEnable)))
			begin
				respNext.target = TGT_GFX;                              // RULE17
				respNext.rdata  = isRead ? ioRdata : 8'h00;
			end
			else
			begin
				respNext.target = TGT_HUB;
			end
		end
		else if (addr >= FOUR_GB)
		begin
			// claimed and finished here, nothing goes forward
			respNext.target    = TGT_TERM;                              // RULE1
			respNext.readZero  = isRead;
			respNext.dropWrite = req.write;
			respNext.fwdAddr   = 32'h0000_0000;
		end
		else if (addr < DOS_END)
		begin
			respNext.target = TGT_DRAM;                                 // RULE3
		end
		else if (inVga)
		begin
			// shadow bits play no part; host and hub see the same steering except for host SMM accesses with smmVgaOpen set
			if (req.smm && !req.fromHub && cfg.smmVgaOpen)
			begin
				respNext.target = TGT_DRAM;                             // RULE6
			end
			else if (inPageWin && pageWinOn)
			begin
				respNext.target  = TGT_GFX;                             // RULE20
				respNext.toCache = addrMapReg[MAP_TO_CACHE];            // RULE21
				respNext.fwdAddr = addrMapReg[MAP_TO_CACHE]
					? {8'h00, pageSelReg, addr[15:0]}                   // RULE2
					: {16'h0000, addr[15:0]};
			end
			else if (inMda)
			begin
				respNext.target = (gfxVga && cfg.mdaEnable) ? TGT_GFX : TGT_HUB; // RULE10
			end
			else
			begin
				respNext.target = gfxVga ? TGT_GFX : TGT_HUB;           // RULE4 RULE5
			end
		end
		else if (inShadow)
		begin
			// segment attribute picks DRAM or hub per direction; an enabled CD hole always goes to hub
			if (inCdHole && cfg.cdHoleEnable)
			begin
				respNext.target = TGT_HUB;                              // RULE8
			end
			else if (isRead)
			begin
				respNext.target = attr[ATTR_RE] ? TGT_DRAM : TGT_HUB;   // RULE7
			end
			else
			begin
				respNext.target = attr[ATTR_WE] ? TGT_DRAM : TGT_HUB;   // RULE7
			end
		end
		else if (addr < top_of_memory)
		begin
			// main DRAM with its optional holes
			if (inIsaHole)
			begin
				respNext.target = TGT_HUB;                              // RULE12
			end
			else if (inTseg)
			begin
				respNext.target = (req.smm && !req.fromHub) ? TGT_DRAM : TGT_HUB; // RULE13
			end
			else if (inStolen)
			begin
				respNext.target = TGT_GFX;                              // RULE14
			end
			else
			begin
				respNext.target = TGT_DRAM;                             // RULE11
			end
		end
		else if (inMmio)
		begin
			respNext.target  = TGT_GFX;                                 // RULE16
			respNext.fwdAddr = addr[31:0] - mmioLo[31:0];
		end
		else
		begin
			respNext.target = TGT_HUB;                                  // RULE15
		end
	end

	// decision register; every output leaves from here
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			respReg <= '0;
		end
		else
		begin
			respReg <= respNext;
		end
	end

	assign resp = respReg;

endmodule

// [logic/sys_decode_pkg.sv]
package sys_decode_pkg;

	// routing targets of one access
	typedef enum logic [1:0]
	{
		TGT_DRAM = 2'b00,
		TGT_HUB  = 2'b01,
		TGT_GFX  = 2'b10,
		TGT_TERM = 2'b11
	} target_e;

	// memory map boundaries, byte addresses
	localparam logic [35:0] DOS_END        = 36'h0_000A_0000;
	localparam logic [35:0] VGA_BASE       = 36'h0_000A_0000;
	localparam logic [35:0] PAGE_WIN_END   = 36'h0_000B_0000;
	localparam logic [35:0] MDA_BASE       = 36'h0_000B_0000;
	localparam logic [35:0] MDA_END        = 36'h0_000B_8000;
	localparam logic [35:0] VGA_END        = 36'h0_000C_0000;
	localparam logic [35:0] CD_HOLE_BASE   = 36'h0_000D_C000;
	localparam logic [35:0] CD_HOLE_END    = 36'h0_000E_0000;
	localparam logic [35:0] ONE_MB         = 36'h0_0010_0000;
	localparam logic [35:0] ISA_HOLE_BASE  = 36'h0_00F0_0000;
	localparam logic [35:0] ISA_HOLE_END   = 36'h0_0100_0000;
	localparam logic [35:0] FOUR_GB        = 36'h1_0000_0000;
	localparam logic [35:0] SIZE_512K      = 36'h0_0008_0000;
	localparam logic [35:0] SIZE_1M        = 36'h0_0010_0000;
	localparam logic [35:0] MMIO_SIZE      = 36'h0_0008_0000;

	// shadow segments: index from address bits 17:16 above C0000h
	localparam int          SEG_LSB        = 16;
	localparam int          SEG_CNT        = 4;
	localparam int          CD_SEG         = 1;
	// shadow attribute: bit 0 read enable, bit 1 write enable
	localparam int          ATTR_RE        = 0;
	localparam int          ATTR_WE        = 1;
	localparam int          ATTR_SEG_LSB   = 0;
	localparam int          ATTR_CD_LSB    = 2;

	// graphics memory select codes
	localparam logic [1:0]  GMS_OFF        = 2'h0;
	localparam logic [1:0]  GMS_512K       = 2'h1;

	// graphics index/data ports and indices
	localparam logic [16:0] GFX_INDEX_PORT = 17'h003CE;
	localparam logic [16:0] GFX_DATA_PORT  = 17'h003CF;
	localparam logic [16:0] MDA_IO_LO      = 17'h003B0;
	localparam logic [16:0] MDA_IO_HI      = 17'h003BB;
	localparam logic [16:0] VGA_IO_LO      = 17'h003C0;
	localparam logic [16:0] VGA_IO_HI      = 17'h003DF;
	localparam logic [16:0] HERC_IO_PORT   = 17'h003BF;
	localparam logic [7:0]  ADDR_MAP_INDEX = 8'h10;
	localparam logic [7:0]  PAGE_SEL_INDEX = 8'h11;
	localparam logic [7:0]  PAGE_SEL_RESET = 8'h00;
	localparam logic [7:0]  ADDR_MAP_RESET = 8'h00;
	localparam logic [7:0]  INDEX_RESET    = 8'h00;
	localparam int          MAP_PAGE_EN    = 0;
	localparam int          MAP_TO_CACHE   = 4;

	// one access offered to the decoder
	typedef struct packed {
		logic        valid;
		logic        isIo;
		logic        write;
		logic        smm;
		logic        fromHub;
		logic [35:0] addr;
		logic [7:0]  wdata;
	} request_s;

	// decode controls held in configuration space elsewhere
	typedef struct packed {
		logic [1:0]       graphics_memory_select;
		logic             gfxMemEnable;
		logic             vgaEnable;
		logic             mdaEnable;
		logic             cdHoleEnable;
		logic [3:0][3:0]  shadowAttr;
		logic             fixedHoleEnable;
		logic             smramTopEnable;
		logic             upperSmramSize;
		logic             smmVgaOpen;
		logic [31:0]      topOfMemory;
		logic [12:0]      mmioBase;
	} config_s;

	// routing decision for one access
	typedef struct packed {
		logic        valid;
		target_e     target;
		logic        readZero;
		logic        dropWrite;
		logic        toCache;
		logic [31:0] fwdAddr;
		logic [7:0]  rdata;
	} response_s;

endpackage

// [testbench/sys_decode_chk.sv]
`timescale 1ns/100ps
module sys_decode_chk
(
	input wire logic                      clk,   // host clock
	input wire logic                      reset, // sync reset
	input wire sys_decode_pkg::request_s  req,   // offer
	input wire sys_decode_pkg::config_s   cfg,   // controls
	input wire sys_decode_pkg::response_s resp   // decision
);
	import sys_decode_pkg::*;
	logic        memReq;
	logic [35:0] a;
	logic [18:0] off;
	logic [35:0] top_of_memory;
	// shorthands; only meaningful while an offer is valid
	assign memReq = req.valid && !req.isIo;
	assign a      = req.addr;
	assign off    = req.addr[18:0];
	assign top_of_memory    = {4'h0, cfg.topOfMemory};

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// each decision lands one edge after its offer
	property p_term;
		memReq && a >= FOUR_GB |=> resp.target == TGT_TERM
			&& resp.dropWrite == $past(req.write) && resp.readZero != resp.dropWrite;
	endproperty
	a_term: assert property (p_term) else $error("upper access not terminated");
	property p_dos;
		memReq && a < DOS_END |=> resp.target == TGT_DRAM;
	endproperty
	a_dos: assert property (p_dos) else $error("low area left main memory");
	property p_vga;
		memReq && a >= PAGE_WIN_END && a < VGA_END && cfg.graphics_memory_select == GMS_OFF && !req.smm
			|=> resp.target == TGT_HUB;
	endproperty
	a_vga: assert property (p_vga) else $error("video buffer misrouted");
	property p_cd;
		memReq && cfg.cdHoleEnable && a >= CD_HOLE_BASE && a < CD_HOLE_END
			|=> resp.target == TGT_HUB;
	endproperty
	a_cd: assert property (p_cd) else $error("open cd hole not forwarded");
	property p_isa;
		memReq && cfg.fixedHoleEnable && a >= ISA_HOLE_BASE && a < ISA_HOLE_END
			|=> resp.target == TGT_HUB;
	endproperty
	a_isa: assert property (p_isa) else $error("isa hole not forwarded");
	property p_dram;
		memReq && a >= ISA_HOLE_END && a < top_of_memory && !cfg.smramTopEnable && !cfg.gfxMemEnable
			|=> resp.target == TGT_DRAM;
	endproperty
	a_dram: assert property (p_dram) else $error("extended memory misrouted");
	property p_pci;
		memReq && a >= top_of_memory && a < FOUR_GB && a[31:19] != cfg.mmioBase
			|=> resp.target == TGT_HUB;
	endproperty
	a_pci: assert property (p_pci) else $error("pci region misrouted");
	property p_mmio;
		memReq && a >= top_of_memory && a < FOUR_GB && a[31:19] == cfg.mmioBase
			|=> resp.target == TGT_GFX && resp.fwdAddr == {13'h0, $past(off)};
	endproperty
	a_mmio: assert property (p_mmio) else $error("register window missed");
	property p_hubio;
		req.valid && req.isIo && req.fromHub |=> resp.target == TGT_HUB;
	endproperty
	a_hubio: assert property (p_hubio) else $error("hub port access claimed");
	// main scenarios reached
	c_term: cover property (memReq && a >= FOUR_GB);
	c_cache: cover property (resp.toCache);
	c_gfx: cover property (resp.target == TGT_GFX);
endmodule

// [testbench/access_initiator.sv]
`timescale 1ns/100ps
module access_initiator
(
	input  wire logic                     clk, // host clock
	input  wire sys_decode_pkg::request_s nxt, // offer queued by the bench
	output sys_decode_pkg::request_s      req  // offer on the bus
);
	import sys_decode_pkg::*;
	initial req = '0;
	// offers move on the falling edge; an idle bus carries junk, not a stale copy
	always @(negedge clk)
		if (nxt.valid)
			req <= nxt;
		else
		begin
			req.valid <= 1'b0;
			req.addr  <= ~req.addr;
		end
endmodule

// [testbench/system_memory_address_decoder_tb.sv]
`timescale 1ns/100ps
module system_memory_address_decoder_tb;
	import sys_decode_pkg::*;
	logic        clk;
	logic        reset;
	request_s    nxt;
	request_s    req;
	request_s    r;
	config_s     cfg;
	config_s     c;
	config_s     g;
	response_s   resp;
	response_s   o;
	logic [35:0] a;
	logic [2:0]  e;
	int          fail_count;
	int          samples_checked;
	int          cycles;
	int          seed;

	access_initiator u_init (.clk(clk), .nxt(nxt), .req(req));
	system_memory_address_decoder u_dut (.clk(clk), .reset(reset), .req(req), .cfg(cfg),
		.resp(resp));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard, far above the few hundred accesses issued
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			final_report();
		end
	end

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one offer: queued at a rising edge, decided one edge after it is sampled
	task automatic access(input request_s q, input config_s k);
		@(posedge clk);
		nxt = q;
		@(negedge clk);
		cfg = k;
		@(posedge clk);
		nxt = '0;
		@(negedge clk);
		o = resp;
	endtask
	task automatic io(input logic hub, input logic w, input logic [16:0] p, input logic [7:0] d);
		r = '0;
		r.valid = 1'b1;
		r.isIo = 1'b1;
		r.fromHub = hub;
		r.write = w;
		r.addr = {19'h0, p};
		r.wdata = d;
		access(r, g);
	endtask
	// 0 dram, 1 hub, 2 gfx, 3 term
	function automatic logic [2:0] exp_tgt(input request_s q, input config_s k);
		logic [35:0] x;
		logic [35:0] ts;
		logic [35:0] st;
		logic [3:0]  at;
		x = q.addr;
		ts = {4'h0, k.topOfMemory};
		if (k.smramTopEnable)
			ts = ts - (k.upperSmramSize ? SIZE_1M : SIZE_512K);
		st = ts - ((k.graphics_memory_select == GMS_512K) ? SIZE_512K : SIZE_1M);
		at = k.shadowAttr[x[17:16]];
		if (x >= CD_HOLE_BASE && x < CD_HOLE_END)
			at[1:0] = at[3:2];
		if (x >= FOUR_GB)
			return 3'h3;
		if (x < DOS_END)
			return 3'h0;
		// mono adapter range needs its own enable on top of the legacy steering
		if (x < VGA_END)
			return (q.smm && !q.fromHub && k.smmVgaOpen) ? 3'h0
				: (k.graphics_memory_select != GMS_OFF && k.vgaEnable
				&& (k.mdaEnable || x < MDA_BASE || x >= MDA_END)) ? 3'h2 : 3'h1;
		if (x < ONE_MB)
			return (k.cdHoleEnable && x >= CD_HOLE_BASE && x < CD_HOLE_END) ? 3'h1
				: {2'h0, !at[q.write ? ATTR_WE : ATTR_RE]};
		if (k.fixedHoleEnable && x >= ISA_HOLE_BASE && x < ISA_HOLE_END)
			return 3'h1;
		if (x < {4'h0, k.topOfMemory})
			return (x >= ts) ? {2'h0, !(q.smm && !q.fromHub)}
				: (k.graphics_memory_select != GMS_OFF && k.gfxMemEnable && x >= st) ? 3'h2 : 3'h0;
		return (x[31:19] == k.mmioBase) ? 3'h2 : 3'h1;
	endfunction
	task automatic final_report();
		$display("checked=%0d failed=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		seed = 32'h5f7d328b;
		reset = 1'b1;
		nxt = '0;
		cfg = '0;
		fail_count = 0;
		samples_checked = 0;
		cycles = 0;
		g = '0;
		g.graphics_memory_select = GMS_512K;
		g.vgaEnable = 1'b1;
		g.topOfMemory = 32'h0800_0000;
		g.mmioBase = 13'h1C00;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		// random traffic over every region; ranges kept apart by construction
		repeat (300)
		begin
			c = {$random(seed), $random(seed), $random(seed)};
			c.topOfMemory = 32'h0800_0000;
			c.mmioBase = 13'h1C00;
			r = {$random(seed), $random(seed)};
			r.valid = 1'b1;
			r.isIo = 1'b0;
			a = {$random(seed), $random(seed)};
			case (a[34:32])
				3'h0: r.addr = 36'(a[19:0] % 20'hA0000);
				3'h1: r.addr = 36'hA0000 + a[16:0];
				3'h2: r.addr = 36'hC0000 + a[17:0];
				3'h3: r.addr = 36'h100000 + a[26:0] % 27'h7F00000;
				3'h4: r.addr = 36'h7FFFFFF - a[20:0];
				3'h5: r.addr = 36'hF00000 + a[19:0];
				3'h6: r.addr = a[21] ? 36'hE0000000 + a[18:0] : {5'h1, a[30:0]};
				default: r.addr = {a[35:32] | 4'h1, a[31:0]};
			endcase
			access(r, c);
			e = exp_tgt(r, c);
			check(36'(o.target), 36'(e[1:0]));
			check(36'(o.valid), 36'h1);
			if (e == 3'h2 && r.addr >= {4'h0, c.topOfMemory})
				check(36'(o.fwdAddr), 36'(r.addr[18:0]));
			if (e == 3'h3)
				check(36'({o.readZero, o.dropWrite}), 36'({!r.write, r.write}));
		end
		// page selector: reset value, write, hub write refused, readback
		io(1'b0, 1'b1, GFX_INDEX_PORT, PAGE_SEL_INDEX);
		io(1'b0, 1'b0, GFX_DATA_PORT, 8'h00);
		check(36'(o.rdata), 36'(PAGE_SEL_RESET));
		io(1'b0, 1'b1, GFX_DATA_PORT, 8'h05);
		io(1'b1, 1'b1, GFX_DATA_PORT, 8'hFF);
		check(36'(o.target), 36'(TGT_HUB));
		io(1'b0, 1'b0, GFX_DATA_PORT, 8'h00);
		check(36'(o.rdata), 36'h05);
		// paged window to the display cache, then to the video buffer
		io(1'b0, 1'b1, GFX_INDEX_PORT, ADDR_MAP_INDEX);
		io(1'b0, 1'b1, GFX_DATA_PORT, 8'h11);
		access({1'b1, 4'h0, 36'hA1234, 8'h00}, g);
		check({o.toCache, o.fwdAddr, 3'h0}, {1'b1, 32'h0005_1234, 3'h0});
		io(1'b0, 1'b1, GFX_DATA_PORT, 8'h01);
		access({1'b1, 4'h0, 36'hAFFFF, 8'h00}, g);
		check(36'(o.toCache), 36'h0);
		io(1'b0, 1'b1, GFX_DATA_PORT, 8'h00);
		// wraparound port and the fixed forwarded port both go to the hub
		io(1'b0, 1'b0, 17'h10000, 8'h00);
		check(36'(o.target), 36'(TGT_HUB));
		io(1'b0, 1'b0, HERC_IO_PORT, 8'h00);
		check(36'(o.target), 36'(TGT_HUB));
		final_report();
	end
endmodule

bind system_memory_address_decoder sys_decode_chk u_chk (.clk(clk), .reset(reset),
	.req(req), .cfg(cfg), .resp(resp));
